// ### design/sab_defs.svh
// offsets, fields, reset values and timing counts of the autobuffer unit
`ifndef SAB_DEFS_SVH
`define SAB_DEFS_SVH
`define SAB_OFF_SCE 12'h000
`define SAB_OFF_RX_START 12'h004
`define SAB_OFF_RX_LEN 12'h008
`define SAB_OFF_RX_ADDR 12'h00C
`define SAB_OFF_TX_START 12'h010
`define SAB_OFF_TX_LEN 12'h014
`define SAB_OFF_TX_ADDR 12'h018
`define SAB_OFF_RX_DATA 12'h01C
`define SAB_OFF_TX_DATA 12'h020
`define SAB_OFF_IRQ_STAT 12'h024
`define SAB_OFF_IRQ_EN 12'h028
`define SAB_OFF_IRQ_CLR 12'h02C
`define SAB_OFF_MEM_ADDR 12'h030
`define SAB_OFF_MEM_DATA 12'h034
`define SAB_B_RX_HALT 15
`define SAB_B_RHALF 14
`define SAB_B_RXEN 13
`define SAB_B_TX_HALT 12
`define SAB_B_XHALF 11
`define SAB_B_TXEN 10
`define SAB_SCE_RST 16'h0000
`define SAB_SCE_RO_MASK 16'h4800
`define SAB_FMT_LSB 7
`define SAB_MEM_WORDS 2048
`define SAB_AW 11
`define SAB_LINK_PERIOD_NS 800
`define SAB_CLK_PERIOD_NS 100
`endif

// ### design/sab_pkg.sv
// types of the autobuffer unit
package sab_pkg;
  typedef enum logic [1:0] {SAB_IDLE, SAB_RX, SAB_TX} sab_dma_e;
  typedef logic [10:0] sab_addr_t;
endpackage

// ### design/sab_serial.sv
// full-duplex double-buffered serial shifter, sampled by the bus clock
`timescale 1ns/100ps
`include "sab_defs.svh"
module sab_serial
  import sab_pkg::*;
(
  input wire logic hclk, // bus clock
  input wire logic hresetn, // async reset, low
  input wire logic link_clk, // serial bit clock
  input wire logic link_fs, // frame sync
  input wire logic link_din, // serial data in
  output logic link_dout, // serial data out
  input wire logic [1:0] word_fmt, // 0:16 1:10 2:8 3:12 bits
  input wire logic [15:0] tx_word, // word for transmit buffer
  input wire logic tx_load, // load transmit buffer
  output logic tx_ready, // transmit buffer empty
  output logic [15:0] rx_word, // received word, sign extended
  output logic rx_ready // received word waiting
);
  logic [2:0] clk_s;
  logic [1:0] fs_s, din_s;
  logic [15:0] tx_buf_r, tx_sh_r, rx_sh_r;
  logic tx_full_r, tx_act_r, rx_act_r;
  logic [4:0] tx_cnt_r, rx_cnt_r;
  logic rx_take_r;
  wire rise = clk_s[1] & ~clk_s[2];
  wire fall = ~clk_s[1] & clk_s[2];
  wire [4:0] nbits = (word_fmt == 2'd1) ? 5'd10 : (word_fmt == 2'd2) ? 5'd8 :
    (word_fmt == 2'd3) ? 5'd12 : 5'd16;
  wire [15:0] rx_shift = {rx_sh_r[14:0], din_s[1]};
  wire [15:0] rx_ext = (word_fmt == 2'd1) ? {{6{rx_shift[9]}}, rx_shift[9:0]} :
    (word_fmt == 2'd2) ? {{8{rx_shift[7]}}, rx_shift[7:0]} :
    (word_fmt == 2'd3) ? {{4{rx_shift[11]}}, rx_shift[11:0]} : rx_shift;
  wire rx_last = rx_act_r & (rx_cnt_r == nbits - 5'd1);
  assign tx_ready = ~tx_full_r;
  // first stage of each synchroniser feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_s <= 3'h0;
      fs_s <= 2'h0;
      din_s <= 2'h0;
    end else begin
      clk_s <= {clk_s[1:0], link_clk};
      fs_s <= {fs_s[0], link_fs};
      din_s <= {din_s[0], link_din};
    end
  end
  // transmit: double buffered, shift out on rising edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_buf_r <= 16'h0000;
      tx_sh_r <= 16'h0000;
      tx_full_r <= 1'b0;
      tx_act_r <= 1'b0;
      tx_cnt_r <= 5'h00;
      link_dout <= 1'b0;
    end else begin
      if (tx_load) begin
        tx_buf_r <= tx_word;
        tx_full_r <= 1'b1;
      end
      if (rise) begin
        if (fs_s[1] && tx_full_r && !tx_load) begin
          tx_sh_r <= tx_buf_r << (5'd16 - nbits);
          tx_full_r <= 1'b0;
          tx_act_r <= 1'b1;
          tx_cnt_r <= 5'h00;
        end else if (tx_act_r) begin
          link_dout <= tx_sh_r[15];
          tx_sh_r <= {tx_sh_r[14:0], 1'b0};
          tx_cnt_r <= tx_cnt_r + 5'd1;
          if (tx_cnt_r == nbits - 5'd1) begin
            tx_act_r <= 1'b0;
          end
        end
      end
    end
  end
  // receive: sample on falling edge, ready high for two cycles, word held until the next
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_sh_r <= 16'h0000;
      rx_act_r <= 1'b0;
      rx_cnt_r <= 5'h00;
      rx_word <= 16'h0000;
      rx_ready <= 1'b0;
      rx_take_r <= 1'b0;
    end else begin
      rx_take_r <= 1'b0;
      if (rx_take_r) begin
        rx_ready <= 1'b0;
      end
      if (rx_ready && !rx_take_r) begin
        rx_take_r <= 1'b1;
      end
      if (fall) begin
        if (fs_s[1] && !rx_act_r) begin
          rx_act_r <= 1'b1;
          rx_cnt_r <= 5'h00;
        end else if (rx_act_r) begin
          rx_sh_r <= rx_shift;
          rx_cnt_r <= rx_cnt_r + 5'd1;
          if (rx_last) begin
            rx_act_r <= 1'b0;
            rx_word <= rx_ext;
            rx_ready <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// ### design/sab_unit.sv
// autobuffer unit: AHB-Lite registers, 2K-word memory, serial DMA, interrupts
// Operation
// - full duplex double buffered port for 8, 10, 12 or 16 bit words
// - with autobuffering each word moves to or from the 2K-word memory
// - memory moves happen in hardware without any processor instruction
// - no interrupt for each word while autobuffering
// - interrupt each time a buffer half boundary is crossed
// - autobuffer off means software moves words via data registers
// - own start, length and address registers for each direction
// - upper six control bits configure unit; bits 14 and 11 read only
// - receive halt set clears receive enable at a half boundary
// - receive half bit 0 after first half, 1 after second
// - receive enable selects autobuffered or standard receive
// - transmit halt set clears transmit enable at a half boundary
// - transmit half bit 0 after first half, 1 after second
// - half bits hold the new value when interrupt flag sets
// - transmit enable selects autobuffered or standard transmit
// - transmit fetch, increment, half interrupt clears, end wraps and sets
// - receive store on ready, write enable, out of reset; interrupts, wrap
`timescale 1ns/100ps
`include "sab_defs.svh"
module sab_unit
  import sab_pkg::*;
(
  input wire logic hclk, // bus clock, 10 MHz
  input wire logic hresetn, // async reset, low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write strobe
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  input wire logic link_clk, // serial bit clock
  input wire logic link_fs, // frame sync
  input wire logic link_din, // serial data in
  output logic link_dout, // serial data out
  input wire logic rx_write_en, // receive write enable
  input wire logic rx_out_of_reset, // receiver out of reset
  output logic irq // level interrupt
);
  logic [15:0] sce_r;
  sab_addr_t rx_start_r, rx_len_r, rx_addr_r, tx_start_r, tx_len_r, tx_addr_r;
  sab_addr_t mem_ptr_r;
  logic [15:0] mem_r [0:`SAB_MEM_WORDS-1];
  logic [15:0] tx_data_r;
  logic tx_load_r;
  logic [1:0] stat_r, ien_r;
  logic [1:0] wsync_r, oor_sync_r;
  logic ap_wr_r;
  logic [11:0] ap_off_r;
  sab_dma_e dma_r;
  logic [15:0] rx_word;
  logic rx_ready, tx_ready, rx_seen_r;
  logic [31:0] rd_mux;
  // bus decode
  wire ap_valid = hsel & htrans[1] & hready;
  wire [11:0] off = ap_off_r;
  wire wr = ap_wr_r;
  wire [15:0] wd = hwdata[15:0];
  wire rx_auto = sce_r[`SAB_B_RXEN];
  wire tx_auto = sce_r[`SAB_B_TXEN];
  // half point and end of each buffer
  sab_addr_t rx_next, tx_next;
  assign rx_next = rx_addr_r + 11'd1;
  assign tx_next = tx_addr_r + 11'd1;
  wire rx_half = (rx_next == (rx_len_r >> 1));
  wire rx_end = (rx_next == rx_len_r);
  wire tx_half = (tx_next == (tx_len_r >> 1));
  wire tx_end = (tx_next == tx_len_r);
  // receive request qualified by write enable and out of reset
  wire rx_req = rx_ready & ~rx_seen_r & rx_auto & wsync_r[1] & oor_sync_r[1];
  wire tx_req = tx_ready & ~tx_load_r & tx_auto;
  sab_addr_t rx_phys, tx_phys;
  assign rx_phys = rx_start_r + rx_addr_r;
  assign tx_phys = tx_start_r + tx_addr_r;
  wire rx_evt = (dma_r == SAB_RX) & (rx_half | rx_end);
  wire tx_evt = (dma_r == SAB_TX) & (tx_half | tx_end);
  wire [1:0] evt = {tx_evt, rx_evt};
  wire clr_wr = wr & (off == `SAB_OFF_IRQ_CLR);
  wire [15:0] sce_sw = (sce_r & `SAB_SCE_RO_MASK) | (wd & ~`SAB_SCE_RO_MASK);
  // reads decode in the address phase so hrdata stands through the data phase;
  // a read right behind a write to the same register returns the old value
  wire [11:0] rd_off = haddr[11:0];
  assign rd_mux =
    (rd_off == `SAB_OFF_SCE) ? {16'h0000, sce_r} :
    (rd_off == `SAB_OFF_RX_START) ? {21'h0, rx_start_r} :
    (rd_off == `SAB_OFF_RX_LEN) ? {21'h0, rx_len_r} :
    (rd_off == `SAB_OFF_RX_ADDR) ? {21'h0, rx_addr_r} :
    (rd_off == `SAB_OFF_TX_START) ? {21'h0, tx_start_r} :
    (rd_off == `SAB_OFF_TX_LEN) ? {21'h0, tx_len_r} :
    (rd_off == `SAB_OFF_TX_ADDR) ? {21'h0, tx_addr_r} :
    (rd_off == `SAB_OFF_RX_DATA) ? {16'h0000, rx_word} :
    (rd_off == `SAB_OFF_TX_DATA) ? {16'h0000, tx_data_r} :
    (rd_off == `SAB_OFF_IRQ_STAT) ? {30'h0, stat_r} :
    (rd_off == `SAB_OFF_IRQ_EN) ? {30'h0, ien_r} :
    (rd_off == `SAB_OFF_MEM_ADDR) ? {21'h0, mem_ptr_r} :
    (rd_off == `SAB_OFF_MEM_DATA) ? {16'h0000, mem_r[mem_ptr_r]} : 32'h0000_0000;

  sab_serial u_ser (
    .hclk(hclk),
    .hresetn(hresetn),
    .link_clk(link_clk),
    .link_fs(link_fs),
    .link_din(link_din),
    .link_dout(link_dout),
    .word_fmt(sce_r[`SAB_FMT_LSB+1:`SAB_FMT_LSB]),
    .tx_word(tx_data_r),
    .tx_load(tx_load_r),
    .tx_ready(tx_ready),
    .rx_word(rx_word),
    .rx_ready(rx_ready)
  );

  // slave is always ready, answers okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_r <= 1'b0;
      ap_off_r <= 12'h000;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      ap_wr_r <= ap_valid & hwrite;
      ap_off_r <= haddr[11:0];
      if (ap_valid && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end
  // pins from outside synchronised
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wsync_r <= 2'b00;
      oor_sync_r <= 2'b00;
    end else begin
      wsync_r <= {wsync_r[0], rx_write_en};
      oor_sync_r <= {oor_sync_r[0], rx_out_of_reset};
    end
  end
  // one write port, DMA first: a software word meeting a receive store is lost
  always_ff @(posedge hclk) begin
    if (dma_r == SAB_RX) begin
      mem_r[rx_phys] <= rx_word;
    end else if (wr && off == `SAB_OFF_MEM_DATA) begin
      mem_r[mem_ptr_r] <= wd;
    end
  end
  // dma sequencer; receive served first since its word can be overrun
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dma_r <= SAB_IDLE;
      rx_seen_r <= 1'b0;
    end else begin
      if (!rx_ready) begin
        rx_seen_r <= 1'b0;
      end
      case (dma_r)
        SAB_IDLE: begin
          if (rx_req) begin
            dma_r <= SAB_RX;
            rx_seen_r <= 1'b1;
          end else if (tx_req) begin
            dma_r <= SAB_TX;
          end
        end
        SAB_RX: dma_r <= SAB_IDLE;
        SAB_TX: dma_r <= SAB_IDLE;
        default: dma_r <= SAB_IDLE;
      endcase
    end
  end
  // registers, address generators, half bits and halts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sce_r <= `SAB_SCE_RST;
      rx_start_r <= 11'h000;
      rx_len_r <= 11'h000;
      rx_addr_r <= 11'h000;
      tx_start_r <= 11'h000;
      tx_len_r <= 11'h000;
      tx_addr_r <= 11'h000;
      tx_data_r <= 16'h0000;
      tx_load_r <= 1'b0;
      mem_ptr_r <= 11'h000;
      ien_r <= 2'b00;
    end else begin
      tx_load_r <= 1'b0;
      if (wr) begin
        case (off)
          `SAB_OFF_SCE: sce_r <= sce_sw;
          `SAB_OFF_RX_START: rx_start_r <= wd[10:0];
          `SAB_OFF_RX_LEN: rx_len_r <= wd[10:0];
          `SAB_OFF_RX_ADDR: rx_addr_r <= wd[10:0];
          `SAB_OFF_TX_START: tx_start_r <= wd[10:0];
          `SAB_OFF_TX_LEN: tx_len_r <= wd[10:0];
          `SAB_OFF_TX_ADDR: tx_addr_r <= wd[10:0];
          `SAB_OFF_TX_DATA: begin
            tx_data_r <= wd;
            tx_load_r <= ~tx_auto;
          end
          `SAB_OFF_IRQ_EN: ien_r <= wd[1:0];
          `SAB_OFF_MEM_ADDR: mem_ptr_r <= wd[10:0];
          `SAB_OFF_MEM_DATA: mem_ptr_r <= mem_ptr_r + 11'd1;
          default: ;
        endcase
      end
      if (dma_r == SAB_RX) begin
        rx_addr_r <= rx_end ? 11'h000 : rx_next;
        if (rx_half | rx_end) begin
          sce_r[`SAB_B_RHALF] <= rx_end;
          if (sce_r[`SAB_B_RX_HALT]) begin
            sce_r[`SAB_B_RXEN] <= 1'b0;
          end
        end
      end
      if (dma_r == SAB_TX) begin
        tx_data_r <= mem_r[tx_phys];
        tx_load_r <= 1'b1;
        tx_addr_r <= tx_end ? 11'h000 : tx_next;
        if (tx_half | tx_end) begin
          sce_r[`SAB_B_XHALF] <= tx_end;
          if (sce_r[`SAB_B_TX_HALT]) begin
            sce_r[`SAB_B_TXEN] <= 1'b0;
          end
        end
      end
    end
  end
  // sticky flags; only boundaries set them, set wins over clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_r <= 2'b00;
      irq <= 1'b0;
    end else begin
      stat_r <= (stat_r & ~(clr_wr ? wd[1:0] : 2'b00)) | evt;
      irq <= |(stat_r & ien_r);
    end
  end

  // one word moved at a buffer boundary, per direction
  sequence sab_rx_mid_seq;
    dma_r == SAB_RX && rx_half && !rx_end;
  endsequence
  sequence sab_rx_end_seq;
    dma_r == SAB_RX && rx_end;
  endsequence
  sequence sab_tx_mid_seq;
    dma_r == SAB_TX && tx_half && !tx_end;
  endsequence
  sequence sab_tx_end_seq;
    dma_r == SAB_TX && tx_end;
  endsequence
  sequence sab_rx_halt_seq;
    dma_r == SAB_RX && (rx_half || rx_end) && sce_r[`SAB_B_RX_HALT];
  endsequence
  sequence sab_tx_halt_seq;
    dma_r == SAB_TX && (tx_half || tx_end) && sce_r[`SAB_B_TX_HALT];
  endsequence

  // half bit already written when the flag shows
  AST_RX_HALF_WITH_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
    sab_rx_mid_seq |=> stat_r[0] && !sce_r[`SAB_B_RHALF])
    else $error("receive half bit wrong at flag");
  AST_TX_HALF_WITH_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
    sab_tx_mid_seq |=> stat_r[1] && !sce_r[`SAB_B_XHALF])
    else $error("transmit half bit wrong at flag");
  AST_RX_END_WRAP: assert property (@(posedge hclk) disable iff (!hresetn)
    sab_rx_end_seq |=> rx_addr_r == 11'h000 && sce_r[`SAB_B_RHALF] && stat_r[0])
    else $error("receive end did not wrap");
  AST_TX_END_WRAP: assert property (@(posedge hclk) disable iff (!hresetn)
    sab_tx_end_seq |=> tx_addr_r == 11'h000 && sce_r[`SAB_B_XHALF] && stat_r[1])
    else $error("transmit end did not wrap");
  AST_RX_HALT: assert property (@(posedge hclk) disable iff (!hresetn)
    sab_rx_halt_seq |=> !rx_auto)
    else $error("receive halt ignored");
  AST_TX_HALT: assert property (@(posedge hclk) disable iff (!hresetn)
    sab_tx_halt_seq |=> !tx_auto)
    else $error("transmit halt ignored");
  AST_NO_WORD_IRQ: assert property (@(posedge hclk) disable iff (!hresetn)
    (dma_r == SAB_RX && !rx_half && !rx_end && !stat_r[0] && !clr_wr) |=> !stat_r[0])
    else $error("flag set mid buffer");
  AST_TX_NO_WORD_IRQ: assert property (@(posedge hclk) disable iff (!hresetn)
    (dma_r == SAB_TX && !tx_half && !tx_end && !stat_r[1] && !clr_wr) |=> !stat_r[1])
    else $error("transmit flag set mid buffer");
  AST_TX_FETCH_LOADS: assert property (@(posedge hclk) disable iff (!hresetn)
    (dma_r == SAB_TX) |=> tx_load_r)
    else $error("fetched word not loaded");
  AST_STD_NO_DMA: assert property (@(posedge hclk) disable iff (!hresetn)
    (!rx_auto && !tx_auto) |=> (dma_r == SAB_IDLE))
    else $error("memory moved in standard mode");
  AST_IRQ_LEVEL: assert property (@(posedge hclk) disable iff (!hresetn)
    irq == $past(|(stat_r & ien_r)))
    else $error("interrupt line does not follow enabled flags");
  AST_BUS_OKAY: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("bus not ready or not okay");
endmodule

// ### verif/sab_codec_model.sv
// serial codec model on the far side of the port
`timescale 1ns/100ps
module sab_codec_model (
  output logic link_clk, // bit clock, still outside frames
  output logic link_fs, // frame sync
  output logic link_din, // data into the unit
  input wire logic link_dout // data from the unit
);
  initial begin
    link_clk = 1'b0;
    link_fs = 1'b0;
    link_din = 1'b0;
  end
  // one frame of n bits, msb first, both directions at once
  task automatic frame(input int n, input logic [15:0] w, output logic [15:0] got);
    got = 16'h0000;
    link_fs = 1'b1;
    #200 link_clk = 1'b1;
    #400 link_clk = 1'b0;
    #200 link_fs = 1'b0;
    #200;
    for (int i = n - 1; i >= 0; i--) begin
      link_clk = 1'b1;
      #200 link_din = w[i];
      #200 link_clk = 1'b0;
      #200 got = {got[14:0], link_dout};
      #200;
    end
    // released line must not keep the last bit
    link_din = ~link_din;
    #400;
  endtask
endmodule

// ### verif/serial_port_autobuffer_unit_bench.sv
// self-checking bench of the autobuffer unit
`timescale 1ns/100ps
`include "sab_defs.svh"
module serial_port_autobuffer_unit_bench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic rx_write_en = 1'b1;
  logic rx_out_of_reset = 1'b1;
  logic [31:0] hrdata;
  logic hreadyout, hresp, link_clk, link_fs, link_din, link_dout, irq;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic [15:0] seed, got;
  logic [15:0] expm [$];
  logic [15:0] e16;
  int n;
  always #50 hclk = ~hclk;
  sab_unit sab_unit_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link_clk(link_clk),
    .link_fs(link_fs), .link_din(link_din), .link_dout(link_dout),
    .rx_write_en(rx_write_en), .rx_out_of_reset(rx_out_of_reset), .irq(irq));
  sab_codec_model sab_codec_model_inst (.link_clk(link_clk), .link_fs(link_fs),
    .link_din(link_din), .link_dout(link_dout));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    tests_run++;
    if (act !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, act, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, rd);
    chk(rd, e);
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic rxf();
    seed = lfsr(seed);
    sab_codec_model_inst.frame(16, seed, got);
    repeat (10) @(posedge hclk);
  endtask
  task end_of_test;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      end_of_test;
    end
  end
  initial begin
    seed = 16'h16E4;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(`SAB_OFF_SCE, 32'h0);
    wr(`SAB_OFF_SCE, 32'h4800);
    rdc(`SAB_OFF_SCE, 32'h0);
    rdc(12'h040, 32'h0);
    // 8-bit words come back sign extended
    wr(`SAB_OFF_SCE, 32'h0100);
    sab_codec_model_inst.frame(8, 16'h0080, got);
    repeat (10) @(posedge hclk);
    rdc(`SAB_OFF_RX_DATA, 32'hFF80);
    // every word length in standard mode, both directions at once
    for (int f = 0; f < 4; f++) begin
      n = (f == 1) ? 10 : (f == 2) ? 8 : (f == 3) ? 12 : 16;
      seed = lfsr(seed);
      wr(`SAB_OFF_SCE, f << `SAB_FMT_LSB);
      wr(`SAB_OFF_TX_DATA, {16'h0, seed});
      sab_codec_model_inst.frame(n, seed, got);
      repeat (10) @(posedge hclk);
      e16 = seed << (16 - n);
      e16 = $signed(e16) >>> (16 - n);
      rdc(`SAB_OFF_RX_DATA, {16'h0, e16});
      chk({16'h0, got}, {16'h0, seed} & ((32'h1 << n) - 32'h1));
    end
    rdc(`SAB_OFF_IRQ_STAT, 32'h0);
    wr(`SAB_OFF_SCE, 32'h0);
    wr(`SAB_OFF_RX_START, 32'h100);
    wr(`SAB_OFF_RX_LEN, 32'h4);
    wr(`SAB_OFF_RX_ADDR, 32'h0);
    wr(`SAB_OFF_IRQ_EN, 32'h1);
    wr(`SAB_OFF_SCE, 32'h2000);
    for (int k = 0; k < 4; k++) begin
      rxf();
      expm.push_back(seed);
      rdc(`SAB_OFF_RX_ADDR, (k + 1) % 4);
      rdc(`SAB_OFF_IRQ_STAT, k % 2);
      if (k % 2 == 1) begin
        rdc(`SAB_OFF_SCE, (k == 3) ? 32'h6000 : 32'h2000);
        chk({31'h0, irq}, 32'h1);
        wr(`SAB_OFF_IRQ_CLR, 32'h1);
        rdc(`SAB_OFF_IRQ_STAT, 32'h0);
        chk({31'h0, irq}, 32'h0);
      end
    end
    for (int k = 0; k < 4; k++) begin
      wr(`SAB_OFF_MEM_ADDR, 32'h100 + k);
      rdc(`SAB_OFF_MEM_DATA, {16'h0, expm.pop_front()});
    end
    // either qualifier low blocks the store
    for (int k = 0; k < 2; k++) begin
      @(posedge hclk);
      rx_write_en <= (k == 1);
      rx_out_of_reset <= (k == 0);
      rxf();
      rdc(`SAB_OFF_RX_ADDR, 32'h0);
    end
    @(posedge hclk);
    rx_write_en <= 1'b1;
    rx_out_of_reset <= 1'b1;
    wr(`SAB_OFF_SCE, 32'hA000);
    rxf();
    rxf();
    rdc(`SAB_OFF_SCE, 32'h8000);
    wr(`SAB_OFF_IRQ_EN, 32'h0);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    rdc(`SAB_OFF_IRQ_STAT, 32'h1);
    wr(`SAB_OFF_IRQ_CLR, 32'h1);
    rxf();
    rdc(`SAB_OFF_RX_ADDR, 32'h2);
    rdc(`SAB_OFF_RX_DATA, {16'h0, seed});
    wr(`SAB_OFF_MEM_ADDR, 32'h200);
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      expm.push_back(seed);
      wr(`SAB_OFF_MEM_DATA, {16'h0, seed});
    end
    wr(`SAB_OFF_TX_START, 32'h200);
    wr(`SAB_OFF_TX_LEN, 32'h4);
    wr(`SAB_OFF_TX_ADDR, 32'h0);
    wr(`SAB_OFF_IRQ_EN, 32'h2);
    wr(`SAB_OFF_SCE, 32'h0400);
    // the fetch runs one word ahead of the shifter
    for (int k = 0; k < 6; k++) begin
      sab_codec_model_inst.frame(16, 16'h0000, got);
      repeat (10) @(posedge hclk);
      chk({16'h0, got}, {16'h0, expm[k % 4]});
      if (k % 2 == 0) begin
        rdc(`SAB_OFF_SCE, (((k + 2) / 2) % 2 == 0) ? 32'h0C00 : 32'h0400);
        rdc(`SAB_OFF_IRQ_STAT, 32'h2);
        chk({31'h0, irq}, 32'h1);
        wr(`SAB_OFF_IRQ_CLR, 32'h2);
      end
    end
    wr(`SAB_OFF_SCE, 32'h1400);
    sab_codec_model_inst.frame(16, 16'h0000, got);
    repeat (10) @(posedge hclk);
    rdc(`SAB_OFF_SCE, 32'h1800);
    end_of_test;
  end
endmodule
